// ### lfm_pkg.sv
// Shared constants and types of the LED driver fault manager
package lfm_pkg;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_MASK = 4'h8;
	localparam logic [3:0] OFS_STATE = 4'hC;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam int CTRL_RUN_BIT = 0;
	localparam int EV_SEC_OV = 0;
	localparam int EV_FREQUENCY_SETTING_PIN = 1;
	localparam int EV_CURRENT_SETTING_PIN = 2;
	localparam int EV_OT = 3;
	localparam int EV_UV = 4;
	localparam int EV_OUT_OV = 5;
	localparam int EV_REMOVED = 6;
	localparam int EV_SHUTDOWN = 7;
	localparam int NUM_EV = 8;
	localparam int LOW_CYCLES = 32750;
	localparam int MIN_LOW_CYCLES = 8;
	localparam int DEF_CHANNELS = 2;
	typedef enum logic [1:0] {ST_OFF, ST_START, ST_RUN} lfm_state_t;
endpackage

// ### lfm_low_counter.sv
// Counter of consecutive clock cycles with the enable/dimming input low
`timescale 1ns/1ps
`default_nettype none
module lfm_low_counter #(
	parameter int LOW_CYCLES = lfm_pkg::LOW_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic en_dim,
	output logic low_done
);
	logic [15:0] cnt_r;

	if (LOW_CYCLES < lfm_pkg::MIN_LOW_CYCLES || LOW_CYCLES > 65535)
	begin : g_bad_count
		$error("LOW_CYCLES out of range");
	end

	// Saturates so a long low time keeps the done level up
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_r <= 16'h0000;
		else if (en_dim)
			cnt_r <= 16'h0000;
		else if (cnt_r != LOW_CYCLES[15:0])
			cnt_r <= cnt_r + 16'h0001;
	end

	assign low_done = (cnt_r == LOW_CYCLES[15:0]);

	sequence s_held_low;
		!en_dim [*8];
	endsequence

	a_low_count_grow: assert property (@(posedge clk) disable iff (!arst_n)
		s_held_low |-> cnt_r >= 16'h0007)
		else $error("low counter did not advance");
	a_low_count_restart: assert property (@(posedge clk) disable iff (!arst_n)
		en_dim |=> cnt_r == 16'h0000 && !low_done)
		else $error("low counter not restarted by high input");
endmodule // lfm_low_counter
`default_nettype wire

// ### lfm_chan_mask.sv
// Per-channel record of LED strings taken out of operation
`timescale 1ns/1ps
`default_nettype none
module lfm_chan_mask #(
	parameter int N_CH = lfm_pkg::DEF_CHANNELS
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clr,
	input wire logic capture,
	input wire logic [N_CH-1:0] led_open,
	input wire logic [N_CH-1:0] led_overv,
	output logic [N_CH-1:0] removed
);
	if (N_CH < 1 || N_CH > 16)
	begin : g_bad_ch
		$error("N_CH out of range");
	end

	// A new detection wins over a clear in the same cycle
	for (genvar i = 0; i < N_CH; i++)
	begin : g_ch
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
				removed[i] <= 1'b0;
			else
				removed[i] <= (removed[i] & ~clr) | (capture & led_open[i]) | led_overv[i];
		end
	end

	a_open_capture: assert property (@(posedge clk) disable iff (!arst_n)
		capture |=> (removed & $past(led_open)) == $past(led_open))
		else $error("open channel not removed at overvoltage");
	a_short_remove: assert property (@(posedge clk) disable iff (!arst_n)
		!capture && led_overv == '0 && !clr |=> removed == $past(removed))
		else $error("channel removed without cause");
endmodule // lfm_chan_mask
`default_nettype wire

// ### lfm_top.sv
// Fault response controller with Avalon-MM register access
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lfm_top #(
	parameter int N_CH = lfm_pkg::DEF_CHANNELS,
	parameter int LOW_CYCLES = lfm_pkg::LOW_CYCLES
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic EN_DIM,
	input wire logic SEC_OV,
	input wire logic [N_CH-1:0] LED_SHORT,
	input wire logic [N_CH-1:0] LED_OPEN,
	input wire logic [N_CH-1:0] LED_OVERV,
	input wire logic CURRENT_SETTING_PIN_OC,
	input wire logic FREQUENCY_SETTING_PIN_OC,
	input wire logic OUT_OV,
	input wire logic OVER_TEMP,
	input wire logic IN_UV,
	output logic BOOST_EN,
	output logic DISCONNECT_EN,
	output logic [N_CH-1:0] SINK_EN,
	output logic FAULT_FLAG,
	output logic RAISE_VOUT,
	output logic SOFTSTART_GO,
	output logic IRQ
);
	lfm_pkg::lfm_state_t state_r;
	lfm_pkg::lfm_state_t state_nxt;
	logic low_done;
	logic sec_latch_r;
	logic [N_CH-1:0] removed;
	logic capture;
	logic clear_all;
	logic ack_r;
	logic req;
	logic take;
	logic run_en;
	logic [31:0] ctrl_r;
	logic [lfm_pkg::NUM_EV-1:0] status_r;
	logic [lfm_pkg::NUM_EV-1:0] mask_r;
	logic [lfm_pkg::NUM_EV-1:0] ev_lvl;
	logic [lfm_pkg::NUM_EV-1:0] ev_prev_r;
	logic [lfm_pkg::NUM_EV-1:0] ev_rise;
	logic bst_ok;
	logic disc_ok;
	logic sink_ok;
	logic start_ok;

	lfm_low_counter #(
		.LOW_CYCLES(LOW_CYCLES)
	) u_low (
		.clk(CLK),
		.arst_n(ARST_N),
		.en_dim(EN_DIM),
		.low_done(low_done)
	);

	lfm_chan_mask #(
		.N_CH(N_CH)
	) u_mask (
		.clk(CLK),
		.arst_n(ARST_N),
		.clr(clear_all),
		.capture(capture),
		.led_open(LED_OPEN),
		.led_overv(LED_OVERV),
		.removed(removed)
	);

	// Shutdown and undervoltage both wipe every latched fault
	assign clear_all = IN_UV | low_done;
	assign run_en = ctrl_r[lfm_pkg::CTRL_RUN_BIT];

	// Set wins so a fault arriving during the clear is never lost
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			sec_latch_r <= 1'b0;
		else
			sec_latch_r <= SEC_OV | (sec_latch_r & ~clear_all);
	end

	assign start_ok = (LED_SHORT == '0) & ~sec_latch_r & ~SEC_OV & ~FREQUENCY_SETTING_PIN_OC & ~OVER_TEMP;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			lfm_pkg::ST_OFF:
				if (EN_DIM && !IN_UV)
					state_nxt = lfm_pkg::ST_START;
			lfm_pkg::ST_START:
				if (start_ok)
					state_nxt = lfm_pkg::ST_RUN;
			lfm_pkg::ST_RUN:
				if (SEC_OV || FREQUENCY_SETTING_PIN_OC || OVER_TEMP)
					state_nxt = lfm_pkg::ST_START;
			default:
				state_nxt = lfm_pkg::ST_OFF;
		endcase
		if (clear_all)
			state_nxt = lfm_pkg::ST_OFF;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			state_r <= lfm_pkg::ST_OFF;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			SOFTSTART_GO <= 1'b0;
		else
			SOFTSTART_GO <= (state_r == lfm_pkg::ST_START) && (state_nxt == lfm_pkg::ST_RUN);
	end

	// Permissions of all active faults are ANDed, most restrictive wins
	assign bst_ok = (state_r == lfm_pkg::ST_RUN) & run_en & ~SEC_OV & ~sec_latch_r
		& ~CURRENT_SETTING_PIN_OC & ~FREQUENCY_SETTING_PIN_OC & ~OUT_OV & ~OVER_TEMP & ~IN_UV;
	assign disc_ok = (state_r != lfm_pkg::ST_OFF) & run_en & ~SEC_OV & ~sec_latch_r
		& ~FREQUENCY_SETTING_PIN_OC & ~OVER_TEMP & ~clear_all;
	assign sink_ok = (state_r == lfm_pkg::ST_RUN) & run_en & ~SEC_OV & ~sec_latch_r
		& ~CURRENT_SETTING_PIN_OC & ~FREQUENCY_SETTING_PIN_OC & ~OVER_TEMP & ~clear_all;

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			BOOST_EN <= 1'b0;
			DISCONNECT_EN <= 1'b0;
			SINK_EN <= '0;
			FAULT_FLAG <= 1'b0;
		end
		else
		begin
			BOOST_EN <= bst_ok;
			DISCONNECT_EN <= disc_ok;
			SINK_EN <= {N_CH{sink_ok}} & ~removed;
			FAULT_FLAG <= (SEC_OV | sec_latch_r | FREQUENCY_SETTING_PIN_OC) & ~clear_all;
		end
	end

	// Open search: push the output up until overvoltage names the open pins
	assign capture = (state_r == lfm_pkg::ST_RUN) & OUT_OV & ~clear_all;

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			RAISE_VOUT <= 1'b0;
		else
			RAISE_VOUT <= (state_r == lfm_pkg::ST_RUN) & ((LED_OPEN & ~removed) != '0) & ~OUT_OV;
	end

	// Avalon slave: one wait cycle, data registered at the release edge
	assign req = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~ack_r;
	assign take = req & ack_r;

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			AVS_READDATA <= 32'h0000_0000;
		else if (AVS_READ && !ack_r)
		begin
			if (AVS_ADDRESS == lfm_pkg::OFS_CTRL)
				AVS_READDATA <= ctrl_r;
			else if (AVS_ADDRESS == lfm_pkg::OFS_STATUS)
				AVS_READDATA <= {24'h00_0000, status_r};
			else if (AVS_ADDRESS == lfm_pkg::OFS_MASK)
				AVS_READDATA <= {24'h00_0000, mask_r};
			else if (AVS_ADDRESS == lfm_pkg::OFS_STATE)
				AVS_READDATA <= {12'h000, 16'(removed), FAULT_FLAG, sec_latch_r, state_r};
			else
				AVS_READDATA <= 32'h0000_0000;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ctrl_r <= lfm_pkg::CTRL_RST;
			mask_r <= lfm_pkg::MASK_RST;
		end
		else if (take && AVS_WRITE)
		begin
			if (AVS_ADDRESS == lfm_pkg::OFS_CTRL)
				ctrl_r <= {31'h0000_0000, AVS_WRITEDATA[lfm_pkg::CTRL_RUN_BIT]};
			else if (AVS_ADDRESS == lfm_pkg::OFS_MASK)
				mask_r <= AVS_WRITEDATA[lfm_pkg::NUM_EV-1:0];
		end
	end

	// Fault events caught on their rising edge
	assign ev_lvl[lfm_pkg::EV_SEC_OV] = sec_latch_r;
	assign ev_lvl[lfm_pkg::EV_FREQUENCY_SETTING_PIN] = FREQUENCY_SETTING_PIN_OC;
	assign ev_lvl[lfm_pkg::EV_CURRENT_SETTING_PIN] = CURRENT_SETTING_PIN_OC;
	assign ev_lvl[lfm_pkg::EV_OT] = OVER_TEMP;
	assign ev_lvl[lfm_pkg::EV_UV] = IN_UV;
	assign ev_lvl[lfm_pkg::EV_OUT_OV] = OUT_OV;
	assign ev_lvl[lfm_pkg::EV_REMOVED] = removed != '0;
	assign ev_lvl[lfm_pkg::EV_SHUTDOWN] = low_done;
	assign ev_rise = ev_lvl & ~ev_prev_r;

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			ev_prev_r <= '0;
		else
			ev_prev_r <= ev_lvl;
	end

	// A read clears status, but an event in the same cycle survives
	for (genvar e = 0; e < lfm_pkg::NUM_EV; e++)
	begin : g_stat
		always_ff @(posedge CLK or negedge ARST_N)
		begin
			if (!ARST_N)
				status_r[e] <= 1'b0;
			else if (ev_rise[e])
				status_r[e] <= 1'b1;
			else if (take && AVS_READ && AVS_ADDRESS == lfm_pkg::OFS_STATUS)
				status_r[e] <= 1'b0;
		end
	end

	assign IRQ = (status_r & mask_r) != '0;

	sequence s_frequency_setting_pin_hit;
		state_r == lfm_pkg::ST_RUN && FREQUENCY_SETTING_PIN_OC;
	endsequence

	sequence s_back_to_start;
		state_r == lfm_pkg::ST_START && !SOFTSTART_GO;
	endsequence

	a_sec_latch_off: assert property (@(posedge CLK) disable iff (!ARST_N)
		SEC_OV |=> !BOOST_EN && !DISCONNECT_EN && SINK_EN == '0 && FAULT_FLAG)
		else $error("secondary overvoltage did not shut down");
	a_sec_latch_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
		sec_latch_r && !low_done && !IN_UV |=> sec_latch_r)
		else $error("latch left without low time");
	a_short_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
		state_r == lfm_pkg::ST_START && LED_SHORT != '0 && !clear_all |=>
		state_r == lfm_pkg::ST_START && !BOOST_EN && SINK_EN == '0)
		else $error("startup continued with a shorted pin");
	a_current_setting_pin_off: assert property (@(posedge CLK) disable iff (!ARST_N)
		CURRENT_SETTING_PIN_OC |=> !BOOST_EN && SINK_EN == '0 && !$past(sec_latch_r | SEC_OV | FREQUENCY_SETTING_PIN_OC) == !FAULT_FLAG)
		else $error("current-setting fault response wrong");
	a_frequency_setting_pin_off: assert property (@(posedge CLK) disable iff (!ARST_N)
		FREQUENCY_SETTING_PIN_OC && !clear_all |=> !DISCONNECT_EN && !BOOST_EN && FAULT_FLAG)
		else $error("frequency-setting fault response wrong");
	a_frequency_setting_pin_restart: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_frequency_setting_pin_hit and !clear_all |=> s_back_to_start)
		else $error("no fresh soft-start after frequency fault");
	a_ovp_halt: assert property (@(posedge CLK) disable iff (!ARST_N)
		OUT_OV |=> !BOOST_EN)
		else $error("boost kept switching during overvoltage");
	a_ot_off: assert property (@(posedge CLK) disable iff (!ARST_N)
		OVER_TEMP |=> !BOOST_EN && !DISCONNECT_EN && SINK_EN == '0)
		else $error("overtemperature did not turn off");
	a_uv_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
		IN_UV && !SEC_OV |=> !sec_latch_r && !FAULT_FLAG && state_r == lfm_pkg::ST_OFF)
		else $error("undervoltage did not clear faults");
	a_low_shutdown: assert property (@(posedge CLK) disable iff (!ARST_N)
		low_done |=> state_r == lfm_pkg::ST_OFF && !DISCONNECT_EN ##1 removed == '0 || LED_OVERV != '0)
		else $error("shutdown not entered");
	a_run_permit: assert property (@(posedge CLK) disable iff (!ARST_N)
		BOOST_EN |-> $past(state_r == lfm_pkg::ST_RUN && !OUT_OV && !CURRENT_SETTING_PIN_OC && run_en))
		else $error("boost enabled without permission");
endmodule // lfm_top
`default_nettype wire

// ### lfm_sys_ctrl.sv
// System controller model driving the enable/dimming input
`timescale 1ns/1ps
`default_nettype none
module lfm_sys_ctrl (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic go_low,
	output logic en_dim
);
	// Registered so the input only moves just after a rising edge, never mid-cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			en_dim <= 1'b1;
		else
			en_dim <= !go_low;
	end
endmodule // lfm_sys_ctrl
`default_nettype wire

// ### tb_led_driver_fault_manager.sv
// Self-checking testbench of the LED driver fault manager
`timescale 1ns/1ps
`default_nettype none
module tb_led_driver_fault_manager;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic [31:0] d;
	logic wreq, en_dim, go_low = 1'b0;
	logic sec = 1'b0, current_setting_pin = 1'b0, frequency_setting_pin = 1'b0, oov = 1'b0, ot = 1'b0, uv = 1'b0;
	logic [1:0] shrt = 2'h1, opn = 2'h0, ovv = 2'h0, sink;
	logic boost, disc, flag, raise, ss_go, irq;
	int checks = 0;
	int num_errors = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	lfm_sys_ctrl lfm_sys_ctrl_inst (.clk(clk), .arst_n(arst_n), .go_low(go_low), .en_dim(en_dim));
	lfm_top #(.N_CH(2), .LOW_CYCLES(16)) lfm_top_inst (.CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
		.EN_DIM(en_dim), .SEC_OV(sec), .LED_SHORT(shrt), .LED_OPEN(opn), .LED_OVERV(ovv), .CURRENT_SETTING_PIN_OC(current_setting_pin),
		.FREQUENCY_SETTING_PIN_OC(frequency_setting_pin), .OUT_OV(oov), .OVER_TEMP(ot), .IN_UV(uv), .BOOST_EN(boost), .DISCONNECT_EN(disc),
		.SINK_EN(sink), .FAULT_FLAG(flag), .RAISE_VOUT(raise), .SOFTSTART_GO(ss_go), .IRQ(irq));
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Outputs are looked at mid-cycle, where every edge update has landed
	task automatic outs(input string name, input logic [4:0] exp);
		@(negedge clk);
		check(name, {boost, disc, sink, flag}, {27'h0, exp});
		@(posedge clk);
	endtask
	// One Avalon transfer; waitrequest and read data are taken at the rising edge itself
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wd <= v;
		rd <= !w;
		wr <= w;
		@(posedge clk);
		while (wreq !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 20)
			check("waitrequest", wreq, 1'b0);
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// Raise a set of auto-restart faults, check the response, then the restart
	task automatic hit(input logic [3:0] f, input logic [4:0] exp);
		{current_setting_pin, frequency_setting_pin, ot, oov} <= f;
		step(3);
		outs("fault response", exp);
		step(1);
		{current_setting_pin, frequency_setting_pin, ot, oov} <= 4'h0;
		step(10);
		outs("restart", 5'b11110);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			tally_and_finish;
		end
	end
	initial
	begin
		step(3);
		arst_n <= 1'b1;
		step(6);
		outs("short hold", 5'b01000);
		shrt <= 2'h0;
		step(8);
		outs("start", 5'b11110);
		$display("test startup done");
		bus(1'b0, lfm_pkg::OFS_CTRL, 32'h0);
		check("ctrl reset", d, lfm_pkg::CTRL_RST);
		bus(1'b0, lfm_pkg::OFS_MASK, 32'h0);
		check("mask reset", d, {24'h0, lfm_pkg::MASK_RST});
		bus(1'b1, 4'h2, 32'hFFFF_FFFF);
		bus(1'b0, 4'h2, 32'h0);
		check("unmapped", d, 32'h0);
		$display("test registers done");
		hit(4'b1000, 5'b01000);
		hit(4'b0100, 5'b00001);
		hit(4'b0010, 5'b00000);
		hit(4'b0001, 5'b01110);
		hit(4'b1001, 5'b01000);
		$display("test auto restart done");
		ovv <= 2'h2;
		step(3);
		ovv <= 2'h0;
		outs("overvolt pin", 5'b11010);
		step(1);
		opn <= 2'h1;
		step(3);
		@(negedge clk);
		check("raise vout", raise, 1'b1);
		step(1);
		oov <= 1'b1;
		step(4);
		outs("open found", 5'b01000);
		step(1);
		oov <= 1'b0;
		opn <= 2'h0;
		step(4);
		outs("open removed", 5'b11000);
		$display("test channel removal done");
		bus(1'b0, lfm_pkg::OFS_STATUS, 32'h0);
		bus(1'b1, lfm_pkg::OFS_MASK, 32'h1);
		sec <= 1'b1;
		step(1);
		sec <= 1'b0;
		step(2);
		outs("latched", 5'b00001);
		check("irq set", irq, 1'b1);
		bus(1'b1, lfm_pkg::OFS_MASK, 32'h0);
		@(negedge clk);
		check("irq masked", irq, 1'b0);
		bus(1'b1, lfm_pkg::OFS_MASK, 32'h1);
		bus(1'b0, lfm_pkg::OFS_STATUS, 32'h0);
		check("status", d[0], 1'b1);
		@(negedge clk);
		check("irq cleared", irq, 1'b0);
		step(1);
		go_low <= 1'b1;
		step(10);
		go_low <= 1'b0;
		step(3);
		outs("short low", 5'b00001);
		step(1);
		go_low <= 1'b1;
		step(20);
		go_low <= 1'b0;
		step(10);
		outs("latch exit", 5'b11110);
		$display("test latched fault done");
		sec <= 1'b1;
		step(1);
		sec <= 1'b0;
		step(3);
		uv <= 1'b1;
		step(3);
		outs("undervoltage", 5'b00000);
		step(1);
		uv <= 1'b0;
		step(10);
		outs("uv restart", 5'b11110);
		$display("test undervoltage done");
		tally_and_finish;
	end
endmodule // tb_led_driver_fault_manager
`default_nettype wire
